/* src/sbbm_byte_master.sv */
/*
  serial bus byte master with configuration registers b0h..b3h and the
  auto-load status; bit engine runs on linkClk and makes the serial clock.
  assumes cfg comes from core_clk logic and pins resolve open-drain outside.
*/
// How it works
// - writing slave address launches a request and sets request busy.
// - read: busy clears on the same edge that loads the received byte into the data register.
// - index register byte goes out as the word address.
// - address bits 7..1 name the addressed slave.
// - address bit 0 is driven as the direction bit in short form; full form sends 0, then 1 after a repeated start for reads.
// - direction 0 means byte write, 1 means byte read.
// - short protocol select drops the index byte from the transaction.
// - status bit 6 always reads zero.
// - rom busy reads 1 only while the auto-load runs.
// - bus present shows the clock line pull-up seen after reset.
// - fast clock test raises the serial clock above its 100 kHz rate.
// - missing acknowledge on a request sets request error; write 1 clears.
// - auto-load acknowledge or format fault sets rom error; write 1 clears.
// - the registers reset to zero only on the global reset.
// - data register holds byte to send or byte received.
module sbbm_byte_master #(
  parameter logic [6:0] ROM_SLAVE = 7'h50,
  parameter logic [7:0] ROM_INDEX = 8'h00,
  parameter logic [7:0] ROM_MARK = 8'ha5
) (
  // core side
  input wire logic core_clk,
  input wire logic resetn,
  // configuration access
  input wire sbbm_pkg::sbbm_cfg_t cfg,
  output logic [7:0] cfgRdData,
  // link side
  input wire logic linkClk,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);
  import sbbm_pkg::*;

  logic [7:0] byteData, byteIndex, targetAddr;
  logic shortSel, fastTest, reqErr, romErr, request_busy, rom_load_busy, busPresent, reqTgl;
  logic doneSync1, doneSync2, doneSeen, sclSync1, sclSync2;
  logic [1:0] detCnt;
  sbbm_rstate_t romSt;
  sbbm_req_t reqHold;
  // link domain
  sbbm_rsp_t rsp;
  logic doneTgl, lrst1, linkRstN, reqS1, reqS2, reqSeen, fastS1, fastS2, sdaS1, sdaS2, nack;
  sbbm_lstate_t lst;
  logic [1:0] q;
  logic [3:0] bitCnt;
  logic [5:0] tickCnt;
  logic [7:0] rxShift;

  // register decode
  wire logic wrData = cfg.wrEn && cfg.addr == OFS_DATA;
  wire logic wrIndex = cfg.wrEn && cfg.addr == OFS_INDEX;
  wire logic wrAddr = cfg.wrEn && cfg.addr == OFS_ADDR;
  wire logic wrCtrl = cfg.wrEn && cfg.addr == OFS_CTRL;
  wire logic doneEvt = doneSync2 != doneSeen;
  wire logic engineBusy = request_busy || rom_load_busy || romSt == R_DETECT;
  wire logic swLaunch = wrAddr && !engineBusy;
  wire logic romLaunch = romSt == R_DETECT && detCnt == DETECT_CYC && sclSync2;
  wire logic swDone = doneEvt && request_busy;
  wire logic romDone = doneEvt && rom_load_busy;
  wire logic romBad = rsp.err || rsp.rx != ROM_MARK;
  wire logic [7:0] statusWord = {shortSel, 1'b0, request_busy, rom_load_busy, busPresent, fastTest, reqErr, romErr};
  wire logic [7:0] rdMux = cfg.addr == OFS_DATA ? byteData :
    cfg.addr == OFS_INDEX ? byteIndex :
    cfg.addr == OFS_ADDR ? targetAddr :
    cfg.addr == OFS_CTRL ? statusWord : RST_BYTE;
  // direction from bit 0, slave from bits 7..1
  wire sbbm_req_t next_req = romLaunch ?
    sbbm_req_t'{shortSel: 1'b0, rd: 1'b1, addr: ROM_SLAVE, index: ROM_INDEX, data: RST_BYTE} :
    sbbm_req_t'{shortSel: shortSel, rd: cfg.wdata[0], addr: cfg.wdata[7:1], index: byteIndex, data: byteData};

  // global reset only; except cfgRdData, which also clears whenever no read is requested
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      byteData <= RST_BYTE;
      byteIndex <= RST_BYTE;
      targetAddr <= RST_BYTE;
      shortSel <= 1'b0;
      fastTest <= 1'b0;
      cfgRdData <= RST_BYTE;
    end
    else
    begin
      cfgRdData <= cfg.rdEn ? rdMux : RST_BYTE;
      if (swDone && reqHold.rd)
        byteData <= rsp.rx;
      else if (wrData)
        byteData <= cfg.wdata;
      if (wrIndex)
        byteIndex <= cfg.wdata;
      if (wrAddr)
        targetAddr <= cfg.wdata;
      if (wrCtrl)
      begin
        shortSel <= cfg.wdata[CS_SHORT];
        fastTest <= cfg.wdata[CS_FAST];
      end
    end
  end

  // busy and sticky error flags; a set beats a same-cycle clear
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      request_busy <= 1'b0;
      reqErr <= 1'b0;
      romErr <= 1'b0;
      reqTgl <= 1'b0;
      reqHold <= '0;
    end
    else
    begin
      request_busy <= swLaunch || (request_busy && !doneEvt);
      reqErr <= (swDone && rsp.err) || (reqErr && !(wrCtrl && cfg.wdata[CS_REQ_ERR]));
      romErr <= (romDone && romBad) || (romErr && !(wrCtrl && cfg.wdata[CS_ROM_ERR]));
      if (swLaunch || romLaunch)
      begin
        reqHold <= next_req;
        reqTgl <= ~reqTgl;
      end
    end
  end

  // crossings into core domain and bus detection after reset
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      doneSync1 <= 1'b0;
      doneSync2 <= 1'b0;
      doneSeen <= 1'b0;
      sclSync1 <= 1'b0;
      sclSync2 <= 1'b0;
      detCnt <= 2'h0;
      romSt <= R_DETECT;
      rom_load_busy <= 1'b0;
      busPresent <= 1'b0;
    end
    else
    begin
      doneSync1 <= doneTgl;
      doneSync2 <= doneSync1;
      doneSeen <= doneSync2;
      sclSync1 <= sclIn;
      sclSync2 <= sclSync1;
      unique case (romSt)
        R_DETECT:
        begin
          detCnt <= detCnt + 2'h1;
          if (detCnt == DETECT_CYC)
          begin
            busPresent <= sclSync2;
            rom_load_busy <= sclSync2;
            romSt <= sclSync2 ? R_WAIT : R_DONE;
          end
        end
        R_WAIT:
          if (doneEvt)
          begin
            rom_load_busy <= 1'b0;
            romSt <= R_DONE;
          end
        R_DONE: romSt <= R_DONE;
      endcase
    end
  end

  // link domain timing and transmit selection
  wire logic [5:0] qtrLen = fastS2 ? FAST_QTR_CYC : QTR_CYC;
  wire logic tick = lst != L_IDLE && tickCnt == qtrLen - 6'h01;
  wire logic endUnit = tick && q == 2'h3;
  wire logic isCond = lst == L_START || lst == L_RSTART;
  wire logic inByte = lst == L_ADDR || lst == L_INDEX || lst == L_DATA || lst == L_ADDRRD;
  wire logic reqEvt = reqS2 != reqSeen;
  wire logic [7:0] txByte = lst == L_ADDR ? {reqHold.addr, reqHold.rd & reqHold.shortSel} :
    lst == L_ADDRRD ? {reqHold.addr, 1'b1} :
    lst == L_INDEX ? reqHold.index : reqHold.data;
  wire sbbm_lstate_t afterByte = nack ? L_STOP :
    lst == L_ADDR ? (reqHold.shortSel ? (reqHold.rd ? L_READ : L_DATA) : L_INDEX) :
    lst == L_INDEX ? (reqHold.rd ? L_RSTART : L_DATA) :
    lst == L_ADDRRD ? L_READ : L_STOP;
  wire logic next_sclLow = lst == L_IDLE ? 1'b0 : (isCond || lst == L_STOP) ? q == 2'h0 : q < 2'h2;
  wire logic next_sdaLow = isCond ? q >= 2'h2 :
    lst == L_STOP ? q < 2'h2 :
    (inByte && bitCnt < 4'h8) ? ~txByte[3'h7 - bitCnt[2:0]] : 1'b0;

  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;

  // link reset: asynchronous assert, synchronous release
  always_ff @(posedge linkClk or negedge resetn)
  begin
    if (!resetn)
    begin
      lrst1 <= 1'b0;
      linkRstN <= 1'b0;
    end
    else
    begin
      lrst1 <= 1'b1;
      linkRstN <= lrst1;
    end
  end

  always_ff @(posedge linkClk or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      reqS1 <= 1'b0;
      reqS2 <= 1'b0;
      fastS1 <= 1'b0;
      fastS2 <= 1'b0;
      sdaS1 <= 1'b1;
      sdaS2 <= 1'b1;
      sclOe <= 1'b0;
      sdaOe <= 1'b0;
    end
    else
    begin
      reqS1 <= reqTgl;
      reqS2 <= reqS1;
      fastS1 <= fastTest;
      fastS2 <= fastS1;
      sdaS1 <= sdaIn;
      sdaS2 <= sdaS1;
      sclOe <= next_sclLow;
      sdaOe <= next_sdaLow;
    end
  end

  // bit engine
  always_ff @(posedge linkClk or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      lst <= L_IDLE;
      reqSeen <= 1'b0;
      q <= 2'h0;
      bitCnt <= 4'h0;
      tickCnt <= 6'h00;
      rxShift <= RST_BYTE;
      nack <= 1'b0;
      rsp <= '0;
      doneTgl <= 1'b0;
    end
    else if (lst == L_IDLE)
    begin
      q <= 2'h0;
      bitCnt <= 4'h0;
      tickCnt <= 6'h00;
      nack <= 1'b0;
      if (reqEvt)
      begin
        reqSeen <= reqS2;
        lst <= L_START;
      end
    end
    else
    begin
      tickCnt <= tick ? 6'h00 : tickCnt + 6'h01;
      if (tick)
        q <= q + 2'h1;
      if (tick && q == 2'h2 && inByte && bitCnt == 4'h8)
        nack <= sdaS2;
      if (tick && q == 2'h2 && lst == L_READ && bitCnt < 4'h8)
        rxShift <= {rxShift[6:0], sdaS2};
      if (endUnit)
      begin
        if (isCond)
          lst <= lst == L_START ? L_ADDR : L_ADDRRD;
        else if (lst == L_STOP)
        begin
          rsp <= sbbm_rsp_t'{err: nack, rx: rxShift};
          doneTgl <= ~doneTgl;
          lst <= L_IDLE;
        end
        else if (bitCnt == 4'h8)
        begin
          bitCnt <= 4'h0;
          lst <= lst == L_READ ? L_STOP : afterByte;
        end
        else
          bitCnt <= bitCnt + 4'h1;
      end
    end
  end

  sequence sStartSeen;
    lst == L_START && endUnit;
  endsequence
  sequence sAddrFollows;
    ##1 lst == L_ADDR;
  endsequence

  a_launch_sets_busy: assert property (@(posedge core_clk) disable iff (!resetn) swLaunch |=> request_busy)
    else $error("request not busy after launch");
  a_rsvd_reads_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    cfg.rdEn && cfg.addr == OFS_CTRL |=> !cfgRdData[CS_RSVD])
    else $error("reserved status bit read as one");
  a_req_err_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    wrCtrl && cfg.wdata[CS_REQ_ERR] && !swDone |=> !reqErr)
    else $error("request error not cleared by write of one");
  a_busy_ends_done: assert property (@(posedge core_clk) disable iff (!resetn) swDone |=> !request_busy)
    else $error("request busy outlived the transaction");
  a_read_data_valid: assert property (@(posedge core_clk) disable iff (!resetn)
    swDone && reqHold.rd |=> byteData == $past(rsp.rx))
    else $error("read byte not in data register");
  a_rom_err_set: assert property (@(posedge core_clk) disable iff (!resetn) romDone && romBad |=> romErr)
    else $error("rom error not set on bad load");
  a_rom_busy_excl: assert property (@(posedge core_clk) disable iff (!resetn) rom_load_busy |-> !request_busy && busPresent)
    else $error("rom busy without a detected bus or with a request");
  a_start_then_addr: assert property (@(posedge linkClk) disable iff (!linkRstN) sStartSeen |-> sAddrFollows)
    else $error("start not followed by address");
  a_short_no_index: assert property (@(posedge linkClk) disable iff (!linkRstN)
    lst == L_ADDR && reqHold.shortSel |-> ##1 lst != L_INDEX)
    else $error("index sent in short form");
  a_read_dir_bit: assert property (@(posedge linkClk) disable iff (!linkRstN)
    lst == L_ADDRRD && bitCnt == 4'h7 && q == 2'h1 |-> !sdaOe)
    else $error("read address phase without read bit");
  a_tick_spacing: assert property (@(posedge linkClk) disable iff (!linkRstN)
    tick && !fastS2 && lst != L_STOP |=> !tick [*8])
    else $error("normal serial clock runs too fast");
endmodule : sbbm_byte_master

/* common/sbbm_pkg.sv */
/*
  shared constants and types of the serial bus byte master.
  assumes byte-wide configuration accesses and open-drain pins resolved outside.
*/
package sbbm_pkg;
  // configuration offsets
  localparam logic [7:0] OFS_DATA = 8'hb0;
  localparam logic [7:0] OFS_INDEX = 8'hb1;
  localparam logic [7:0] OFS_ADDR = 8'hb2;
  localparam logic [7:0] OFS_CTRL = 8'hb3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // control/status bit positions
  localparam int CS_SHORT = 7;
  localparam int CS_RSVD = 6;
  localparam int CS_REQ_BUSY = 5;
  localparam int CS_ROM_BUSY = 4;
  localparam int CS_PRESENT = 3;
  localparam int CS_FAST = 2;
  localparam int CS_REQ_ERR = 1;
  localparam int CS_ROM_ERR = 0;
  // serial clock timing
  localparam int SCL_PERIOD_NS = 10000;
  localparam int LINK_CLK_NS = 64;
  localparam logic [5:0] QTR_CYC = 6'((SCL_PERIOD_NS / 4 + LINK_CLK_NS - 1) / LINK_CLK_NS);
  localparam logic [5:0] FAST_QTR_CYC = 6'h04;
  localparam logic [1:0] DETECT_CYC = 2'h3;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sbbm_cfg_t;

  typedef struct packed {
    logic shortSel;
    logic rd;
    logic [6:0] addr;
    logic [7:0] index;
    logic [7:0] data;
  } sbbm_req_t;

  typedef struct packed {
    logic err;
    logic [7:0] rx;
  } sbbm_rsp_t;

  typedef enum logic [3:0] {
    L_IDLE, L_START, L_ADDR, L_INDEX, L_DATA, L_RSTART, L_ADDRRD, L_READ, L_STOP
  } sbbm_lstate_t;

  typedef enum logic [1:0] {R_DETECT, R_WAIT, R_DONE} sbbm_rstate_t;
endpackage : sbbm_pkg

/* dv/sbbm_slave_model.sv */
/*
  two-wire slave model answering at DEV_ADDR; logs every byte it is sent.
  assumes open-drain lines resolved with pull-ups by the bench.
*/
module sbbm_slave_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  // resolved lines
  input wire logic scl,
  input wire logic sda,
  output logic sdaPull,
  // byte returned on reads
  input wire logic [7:0] readByte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'h00;
  logic active = 1'b0;
  logic rdMode = 1'b0;
  logic hit = 1'b0;
  int bitN = 0;
  int byteN = 0;
  logic [7:0] seen[$];
  initial sdaPull = 1'b0;
  // settle past a clock edge landing in the same step
  always @(negedge sda)
  begin
    #1;
    if (scl === 1'b1 && sda === 1'b0)
    begin
      active = 1'b1;
      bitN = 0;
      byteN = 0;
      sdaPull = 1'b0;
    end
  end
  always @(posedge sda)
  begin
    #1;
    if (scl === 1'b1 && sda === 1'b1)
      active = 1'b0;
  end
  always @(posedge scl)
    if (active && bitN < 8)
    begin
      sh = {sh[6:0], sda};
      bitN++;
    end
  always @(negedge scl)
    if (active)
    begin
      if (bitN == 8)
      begin
        if (byteN == 0)
        begin
          hit = (sh[7:1] == DEV_ADDR);
          rdMode = sh[0];
        end
        if (!(rdMode && byteN > 0))
          seen.push_back(sh);
        sdaPull = hit && !(rdMode && byteN > 0);
        bitN = 9;
      end
      else if (bitN == 9)
      begin
        bitN = 0;
        byteN++;
        sdaPull = hit && rdMode && byteN == 1 && !readByte[7];
      end
      else
        sdaPull = hit && rdMode && byteN == 1 && !readByte[7 - bitN];
    end
endmodule : sbbm_slave_model

/* dv/sbbm_byte_master_tb.sv */
/*
  self-checking bench of the byte master with a slave model on the link.
  assumes pull-ups on both lines and the slave model at address 50h.
*/
module sbbm_byte_master_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sbbm_pkg::*;
  logic core_clk = 1'b0;
  logic linkClk = 1'b0;
  logic resetn = 1'b0;
  sbbm_cfg_t cfg = '0;
  logic [7:0] cfgRdData;
  logic sclOut;
  logic sclOe;
  logic sdaOut;
  logic sdaOe;
  logic sdaPull;
  logic [7:0] readByte = 8'ha5;
  int errors = 0;
  int testsRun = 0;
  wire logic sclLine = !sclOe;
  wire logic sdaLine = !(sdaOe || sdaPull);
  always #25 core_clk = ~core_clk;
  always #32 linkClk = ~linkClk;

  sbbm_byte_master sbbm_byte_master_i (.core_clk(core_clk), .resetn(resetn), .cfg(cfg),
    .cfgRdData(cfgRdData), .linkClk(linkClk), .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe));
  sbbm_slave_model slave_i (.scl(sclLine), .sda(sdaLine), .sdaPull(sdaPull), .readByte(readByte));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    cfg = '{1'b1, 1'b0, a, d};
    @(negedge core_clk);
    cfg = '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    cfg = '{1'b0, 1'b1, a, 8'h00};
    @(negedge core_clk);
    cfg = '0;
    d = cfgRdData;
  endtask : rd

  task automatic waitClear(input int b);
    logic [7:0] v;
    v = 8'hff;
    for (int n = 0; n < 20000 && v[b] !== 1'b0; n++)
      rd(OFS_CTRL, v);
    check("flag cleared", {31'h0, v[b]}, 0);
  endtask : waitClear

  task automatic request(input logic [7:0] ctrl, input logic [7:0] ad, input logic [7:0] idx,
      input logic [7:0] dat, input logic [7:0] expW[$], input logic [7:0] expSt);
    logic [7:0] v;
    realtime t1;
    realtime t2;
    wr(OFS_CTRL, ctrl);
    wr(OFS_DATA, dat);
    wr(OFS_INDEX, idx);
    wr(OFS_ADDR, ad);
    rd(OFS_CTRL, v);
    check("request busy", {31'h0, v[CS_REQ_BUSY]}, 1);
    fork
      waitClear(CS_REQ_BUSY);
      begin
        repeat (2) @(posedge sclLine);
        t1 = $realtime;
        @(posedge sclLine);
        t2 = $realtime;
      end
    join
    check("scl period", int'(t2 - t1), 4 * LINK_CLK_NS * (ctrl[CS_FAST] ? FAST_QTR_CYC : QTR_CYC));
    check("pin levels", {30'h0, sclOut, sdaOut}, 0);
    rd(OFS_CTRL, v);
    check("status", v, expSt);
    check("byte count", slave_i.seen.size(), expW.size());
    foreach (expW[i])
      check("wire byte", slave_i.seen[i], expW[i]);
    slave_i.seen.delete();
  endtask : request

  task automatic t_load(input logic [7:0] rom, input logic [7:0] expSt);
    logic [7:0] v;
    readByte = rom;
    @(negedge core_clk);
    resetn = 1'b0;
    repeat (5) @(negedge core_clk);
    resetn = 1'b1;
    repeat (10) @(negedge core_clk);
    rd(OFS_CTRL, v);
    check("load start", v, 8'h18);
    waitClear(CS_ROM_BUSY);
    rd(OFS_CTRL, v);
    check("load status", v, expSt);
    check("rom bytes", slave_i.seen.size(), 3);
    slave_i.seen.delete();
    for (int a = 8'hb0; a < 8'hb3; a++)
    begin
      rd(8'(a), v);
      check("reset value", v, RST_BYTE);
    end
    rd(8'hb4, v);
    check("unmapped", v, 8'h00);
  endtask : t_load

  task automatic t_full_write;
    request(8'h00, 8'ha0, 8'h12, 8'h3c, '{8'ha0, 8'h12, 8'h3c}, 8'h08);
  endtask : t_full_write

  task automatic t_full_read;
    logic [7:0] v;
    readByte = 8'h5a;
    request(8'h04, 8'ha1, 8'h34, 8'hff, '{8'ha0, 8'h34, 8'ha1}, 8'h0c);
    rd(OFS_DATA, v);
    check("read data", v, 8'h5a);
  endtask : t_full_read

  task automatic t_short;
    logic [7:0] v;
    readByte = 8'hc3;
    request(8'h84, 8'ha0, 8'h77, 8'h3c, '{8'ha0, 8'h3c}, 8'h8c);
    request(8'h84, 8'ha1, 8'h77, 8'h00, '{8'ha1}, 8'h8c);
    rd(OFS_DATA, v);
    check("short read data", v, 8'hc3);
  endtask : t_short

  task automatic t_nack;
    logic [7:0] v;
    request(8'h44, 8'h44, 8'h00, 8'h00, '{8'h44}, 8'h0e);
    wr(OFS_CTRL, 8'h06);
    rd(OFS_CTRL, v);
    check("request error cleared", v, 8'h0c);
  endtask : t_nack

  task automatic t_rom_error;
    logic [7:0] v;
    t_load(8'h00, 8'h09);
    wr(OFS_CTRL, 8'h01);
    rd(OFS_CTRL, v);
    check("rom error cleared", v, 8'h08);
  endtask : t_rom_error

  task automatic complete_run;
    if (errors == 0 && testsRun > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  initial
  begin
    t_load(8'ha5, 8'h08);
    t_full_write;
    t_full_read;
    t_short;
    t_nack;
    t_rom_error;
    complete_run;
  end

  initial
  begin
    #4_000_000;
    errors++;
    complete_run;
  end
endmodule : sbbm_byte_master_tb
